// ===== verilog/scrse_top.sv
// Function
// - One sample rate register serves all gyro channels alike.
// - Rate command carries one number; only 0, 125, 250, 500, 1000 accepted.
// - Rate zero selects external trigger and echoes that choice.
// - Any valid rate is taken without warning about filter interplay.
// - Unsaved rate lasts only until init, reset or power loss.
// - Unknown command E001, parameter count or leading comma E002, range E003.
// - Save asks for confirmation and writes flash only on upper-case Y.
// - Save answered N aborts with a message and no error.
// - Any other save answer aborts and reports E003.
// - Completed saves are counted; above 1000 warn E004, still save.
// - Failed flash transfer reports E005.
// - Save takes no parameters; any character before CR gives E002.
// - Successful save reports stored and shows the save counter.
// - Exit n asks for Y when params differ, then holds 3 s.
// - Exit i asks for Y when params differ, then holds 3 s.
// - Exit N enters normal mode at once, no confirmation, no hold.
// - Exit I enters init mode at once, no confirmation, no hold.
// - Entering init reloads all parameters from flash.
// - When params match flash, exit skips confirmation and announces directly.
// - Exit answer other than Y or N stays in service, reports E003.
module scrse_top #(
   parameter int unsigned HOLD_CYCLES = scrse_pkg::HOLD_CYC,
   parameter int CNT_W = scrse_pkg::SAVE_CNT_W
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic flash_done,
   input wire logic flash_ok,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic resp_valid,
   output scrse_pkg::scrse_rsp_t resp_code,
   output logic [2:0] rate_code,
   output logic ext_trig,
   output scrse_pkg::scrse_mode_t mode,
   output logic flash_wr_req,
   output logic [2:0] flash_wr_rate,
   output logic [CNT_W-1:0] save_count
);
   typedef enum logic [2:0] {ST_LINE, ST_SEND, ST_CONF, ST_FLASH, ST_HOLD, ST_LEAVE} scrse_st_t;
   typedef enum logic [1:0] {CK_SAVE, CK_NORMAL, CK_INIT} scrse_conf_t;

   scrse_st_t st_q, after_q;
   scrse_conf_t conf_q;
   scrse_pkg::scrse_rsp_t q0_q, q1_q, q2_q, resp_code_q;
   scrse_pkg::scrse_mode_t mode_q, tgt_q;
   logic [1:0] q_len_q;
   logic resp_valid_q, flash_wr_req_q, waitrequest_q, ext_q, aux_diff_q;
   logic [31:0] readdata_q, hold_cnt_q;
   logic [2:0] rate_q, flash_rate_q;
   logic [CNT_W-1:0] save_cnt_q;
   logic [7:0] cmd_q, arg_ch_q;
   logic have_cmd_q, arg_seen_q, gap_q, comma_first_q, extra_q, nondigit_q, big_q;
   logic [3:0] nchar_q;
   logic [2:0] arg_len_q;
   logic [10:0] num_q;

   // Character classes and line events
   wire svc_w = (mode_q == scrse_pkg::MODE_SERVICE);
   wire take_w = rx_valid && svc_w && (st_q == ST_LINE);
   wire is_cr_w = (rx_data == scrse_pkg::CH_CR);
   wire is_digit_w = (rx_data >= scrse_pkg::CH_D0) && (rx_data <= scrse_pkg::CH_D9);
   wire line_end_w = take_w && is_cr_w;
   wire [10:0] digit_w = {7'h00, rx_data[3:0] - scrse_pkg::CH_D0[3:0]};
   wire [10:0] num_next_w = 11'(num_q * 11'h00a) + digit_w;
   wire conf_take_w = rx_valid && (st_q == ST_CONF) && !is_cr_w && (rx_data != scrse_pkg::CH_LF);
   wire conf_yes_w = conf_take_w && (rx_data == scrse_pkg::CH_YES);
   wire conf_no_w = conf_take_w && (rx_data == scrse_pkg::CH_NO);

   // Live settings compared against flash copy; aux covers other params
   wire differ_w = (rate_q != flash_rate_q) || aux_diff_q;

   // Parameter decode for the rate command
   wire cnt_err_w = comma_first_q || extra_q || !arg_seen_q;
   wire rate_ok_w = (num_q == scrse_pkg::RATE_V125) || (num_q == scrse_pkg::RATE_V250) ||
                    (num_q == scrse_pkg::RATE_V500) || (num_q == scrse_pkg::RATE_V1000);
   wire [2:0] rate_sel_w = (num_q == scrse_pkg::RATE_V125) ? scrse_pkg::RC_125 :
                           (num_q == scrse_pkg::RATE_V250) ? scrse_pkg::RC_250 :
                           (num_q == scrse_pkg::RATE_V500) ? scrse_pkg::RC_500 :
                           (num_q == scrse_pkg::RATE_V1000) ? scrse_pkg::RC_1000 : scrse_pkg::RC_EXT;
   wire rate_val_w = !nondigit_q && !big_q && (rate_ok_w || num_q == 11'h000);
   wire rate_apply_w = line_end_w && have_cmd_q && cmd_q == scrse_pkg::CH_RATE && !cnt_err_w && rate_val_w;
   wire unknown_w = line_end_w && have_cmd_q && cmd_q != scrse_pkg::CH_RATE &&
                    cmd_q != scrse_pkg::CH_SAVE && cmd_q != scrse_pkg::CH_EXIT;
   wire flash_end_w = (st_q == ST_FLASH) && flash_done;
   wire [CNT_W-1:0] cnt_inc_w = save_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

   // Register bus decode; a request completes when waitrequest is low
   wire bus_req_w = read || write;
   wire bus_done_w = bus_req_w && !waitrequest_q;
   wire wr_ctrl_w = write && !waitrequest_q && (address == scrse_pkg::OFS_CTRL);
   wire [31:0] rd_mux_w = (address == scrse_pkg::OFS_STATUS) ?
                             {24'h000000, (st_q != ST_LINE), differ_w, mode_q, ext_q, rate_q} :
                          (address == scrse_pkg::OFS_SAVE_CNT) ? 32'(save_cnt_q) :
                          (address == scrse_pkg::OFS_CTRL) ? {30'h0, aux_diff_q, 1'b0} :
                          (address == scrse_pkg::OFS_FLASH_RATE) ? {29'h0, flash_rate_q} : 32'h00000000;

   // One wait cycle per access; unmapped reads return zero
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         waitrequest_q <= 1'b1;
         readdata_q <= 32'h00000000;
      end else begin
         waitrequest_q <= !(bus_req_w && waitrequest_q);
         if (bus_req_w && waitrequest_q) begin
            readdata_q <= rd_mux_w;
         end
      end
   end

   // Argument collector: counts parameters and flags malformed lines
   always_ff @(posedge clock) begin
      if (!reset_n || line_end_w) begin
         have_cmd_q <= 1'b0;
         cmd_q <= 8'h00;
         arg_ch_q <= 8'h00;
         arg_seen_q <= 1'b0;
         gap_q <= 1'b0;
         comma_first_q <= 1'b0;
         extra_q <= 1'b0;
         nondigit_q <= 1'b0;
         big_q <= 1'b0;
         nchar_q <= 4'h0;
         arg_len_q <= 3'h0;
         num_q <= 11'h000;
      end else if (take_w && !have_cmd_q) begin
         have_cmd_q <= 1'b1;
         cmd_q <= rx_data;
      end else if (take_w) begin
         if (nchar_q != 4'hf) begin
            nchar_q <= nchar_q + 4'h1;
         end
         if (rx_data == scrse_pkg::CH_SP || rx_data == scrse_pkg::CH_COMMA) begin
            gap_q <= arg_seen_q;
            if (rx_data == scrse_pkg::CH_COMMA && !arg_seen_q) begin
               comma_first_q <= 1'b1;
            end
         end else if (gap_q) begin
            extra_q <= 1'b1;
         end else begin
            arg_seen_q <= 1'b1;
            if (!arg_seen_q) begin
               arg_ch_q <= rx_data;
            end
            if (arg_len_q != 3'h7) begin
               arg_len_q <= arg_len_q + 3'h1;
            end
            if (!is_digit_w) begin
               nondigit_q <= 1'b1;
            end else if (num_q < scrse_pkg::NUM_LIMIT) begin
               num_q <= num_next_w;
            end else begin
               big_q <= 1'b1;
            end
         end
      end
   end

   // Settings held outside the command flow
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rate_q <= scrse_pkg::RATE_RST;
         ext_q <= 1'b0;
         flash_rate_q <= scrse_pkg::RATE_RST;
         aux_diff_q <= 1'b0;
         save_cnt_q <= '0;
      end else if (rate_apply_w) begin
         rate_q <= rate_sel_w;
         ext_q <= (rate_sel_w == scrse_pkg::RC_EXT);
      end else if (st_q == ST_LEAVE && tgt_q == scrse_pkg::MODE_INIT) begin
         rate_q <= flash_rate_q;
         ext_q <= (flash_rate_q == scrse_pkg::RC_EXT);
         aux_diff_q <= 1'b0;
      end else if (flash_end_w && flash_ok) begin
         flash_rate_q <= rate_q;
         aux_diff_q <= 1'b0;
         save_cnt_q <= cnt_inc_w;
      end else if (wr_ctrl_w) begin
         aux_diff_q <= writedata[scrse_pkg::CTRL_AUX_DIFF_BIT];
      end
   end

   // Command sequencer; responses leave through a three-deep message queue
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_q <= ST_LINE;
         after_q <= ST_LINE;
         conf_q <= CK_SAVE;
         tgt_q <= scrse_pkg::MODE_NORMAL;
         mode_q <= scrse_pkg::MODE_SERVICE;
         q0_q <= scrse_pkg::RSP_PROMPT;
         q1_q <= scrse_pkg::RSP_PROMPT;
         q2_q <= scrse_pkg::RSP_PROMPT;
         q_len_q <= 2'h0;
         resp_valid_q <= 1'b0;
         resp_code_q <= scrse_pkg::RSP_PROMPT;
         flash_wr_req_q <= 1'b0;
         hold_cnt_q <= 32'h00000000;
      end else begin
         resp_valid_q <= 1'b0;
         flash_wr_req_q <= 1'b0;
         if (mode_q == scrse_pkg::MODE_INIT) begin
            mode_q <= scrse_pkg::MODE_NORMAL; // Init settles into normal after the reload
         end else if (wr_ctrl_w && writedata[scrse_pkg::CTRL_SERVICE_BIT] && !svc_w) begin
            mode_q <= scrse_pkg::MODE_SERVICE;
         end
         case (st_q)
            ST_LINE: begin
               if (line_end_w) begin
                  st_q <= ST_SEND;
                  after_q <= ST_LINE;
                  q1_q <= scrse_pkg::RSP_PROMPT;
                  q_len_q <= 2'h2;
                  if (!have_cmd_q) begin
                     q0_q <= scrse_pkg::RSP_PROMPT;
                     q_len_q <= 2'h1;
                  end else if (cmd_q == scrse_pkg::CH_RATE) begin
                     if (cnt_err_w) begin
                        q0_q <= scrse_pkg::RSP_E002;
                     end else if (!rate_val_w) begin
                        q0_q <= scrse_pkg::RSP_E003;
                     end else if (num_q == 11'h000) begin
                        q0_q <= scrse_pkg::RSP_EXT_TRIG;
                     end else begin
                        q0_q <= scrse_pkg::RSP_RATE;
                     end
                  end else if (cmd_q == scrse_pkg::CH_SAVE) begin
                     if (nchar_q != 4'h0) begin
                        q0_q <= scrse_pkg::RSP_E002;
                     end else begin
                        q0_q <= scrse_pkg::RSP_ASK_SAVE;
                        q_len_q <= 2'h1;
                        after_q <= ST_CONF;
                        conf_q <= CK_SAVE;
                     end
                  end else if (cmd_q == scrse_pkg::CH_EXIT) begin
                     if (cnt_err_w) begin
                        q0_q <= scrse_pkg::RSP_E002;
                     end else if (arg_len_q != 3'h1) begin
                        q0_q <= scrse_pkg::RSP_E003;
                     end else if (arg_ch_q == scrse_pkg::CH_NORM_CONF || arg_ch_q == scrse_pkg::CH_INIT_CONF) begin
                        q_len_q <= 2'h1;
                        tgt_q <= (arg_ch_q == scrse_pkg::CH_INIT_CONF) ? scrse_pkg::MODE_INIT
                                                                      : scrse_pkg::MODE_NORMAL;
                        conf_q <= (arg_ch_q == scrse_pkg::CH_INIT_CONF) ? CK_INIT : CK_NORMAL;
                        if (differ_w) begin
                           q0_q <= scrse_pkg::RSP_ASK_EXIT;
                           after_q <= ST_CONF;
                        end else begin
                           q0_q <= (arg_ch_q == scrse_pkg::CH_INIT_CONF) ? scrse_pkg::RSP_RET_INIT
                                                                         : scrse_pkg::RSP_RET_NORMAL;
                           after_q <= ST_HOLD;
                        end
                     end else if (arg_ch_q == scrse_pkg::CH_NORM_NOW || arg_ch_q == scrse_pkg::CH_INIT_NOW) begin
                        q_len_q <= 2'h1;
                        after_q <= ST_LEAVE;
                        tgt_q <= (arg_ch_q == scrse_pkg::CH_INIT_NOW) ? scrse_pkg::MODE_INIT
                                                                     : scrse_pkg::MODE_NORMAL;
                        q0_q <= (arg_ch_q == scrse_pkg::CH_INIT_NOW) ? scrse_pkg::RSP_RET_INIT
                                                                    : scrse_pkg::RSP_RET_NORMAL;
                     end else begin
                        q0_q <= scrse_pkg::RSP_E003;
                     end
                  end else begin
                     q0_q <= scrse_pkg::RSP_E001;
                  end
               end
            end
            ST_SEND: begin
               resp_valid_q <= 1'b1;
               resp_code_q <= q0_q;
               q0_q <= q1_q;
               q1_q <= q2_q;
               q_len_q <= q_len_q - 2'h1;
               if (q_len_q == 2'h1) begin
                  st_q <= after_q;
                  hold_cnt_q <= HOLD_CYCLES - 32'h00000001;
                  flash_wr_req_q <= (after_q == ST_FLASH);
               end
            end
            ST_CONF: begin
               // Line ends around the answer are skipped; the first other character decides
               if (conf_take_w) begin
                  st_q <= ST_SEND;
                  after_q <= ST_LINE;
                  q1_q <= scrse_pkg::RSP_PROMPT;
                  q_len_q <= (conf_q == CK_SAVE) ? 2'h2 : 2'h1;
                  if (conf_yes_w && conf_q == CK_SAVE) begin
                     st_q <= ST_FLASH;
                     flash_wr_req_q <= 1'b1;
                  end else if (conf_yes_w) begin
                     q0_q <= (conf_q == CK_INIT) ? scrse_pkg::RSP_RET_INIT : scrse_pkg::RSP_RET_NORMAL;
                     after_q <= ST_HOLD;
                  end else if (conf_no_w) begin
                     q0_q <= (conf_q == CK_SAVE) ? scrse_pkg::RSP_SAVE_ABORTED : scrse_pkg::RSP_PROMPT;
                  end else if (conf_q == CK_SAVE) begin
                     q0_q <= scrse_pkg::RSP_SAVE_ABORTED;
                     q1_q <= scrse_pkg::RSP_E003;
                     q2_q <= scrse_pkg::RSP_PROMPT;
                     q_len_q <= 2'h3;
                  end else begin
                     q0_q <= scrse_pkg::RSP_E003;
                     q_len_q <= 2'h2;
                  end
               end
            end
            ST_FLASH: begin
               // Flash busy time is the flash's own; no timeout is imposed here
               if (flash_done) begin
                  st_q <= ST_SEND;
                  after_q <= ST_LINE;
                  q_len_q <= 2'h2;
                  q0_q <= flash_ok ? scrse_pkg::RSP_SAVED : scrse_pkg::RSP_E005;
                  q1_q <= scrse_pkg::RSP_PROMPT;
                  if (flash_ok && cnt_inc_w > CNT_W'(scrse_pkg::SAVE_WARN_LIMIT)) begin
                     q1_q <= scrse_pkg::RSP_E004;
                     q2_q <= scrse_pkg::RSP_PROMPT;
                     q_len_q <= 2'h3;
                  end
               end
            end
            ST_HOLD: begin
               if (hold_cnt_q == 32'h00000000) begin
                  st_q <= ST_LEAVE;
               end else begin
                  hold_cnt_q <= hold_cnt_q - 32'h00000001;
               end
            end
            ST_LEAVE: begin
               mode_q <= tgt_q;
               st_q <= ST_LINE;
            end
            default: begin
               st_q <= ST_LINE;
            end
         endcase
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign resp_valid = resp_valid_q;
   assign resp_code = resp_code_q;
   assign rate_code = rate_q;
   assign ext_trig = ext_q;
   assign mode = mode_q;
   assign flash_wr_req = flash_wr_req_q;
   assign flash_wr_rate = rate_q;
   assign save_count = save_cnt_q;

   // Checks on the interpreter's own outputs
   AST_RATE_LEGAL: assert property (@(posedge clock) disable iff (!reset_n)
      rate_q <= scrse_pkg::RC_1000 && ext_q == (rate_q == scrse_pkg::RC_EXT))
      else $error("rate code out of range or trigger flag mismatch");
   AST_EXT_ECHO: assert property (@(posedge clock) disable iff (!reset_n)
      resp_valid_q && resp_code_q == scrse_pkg::RSP_EXT_TRIG |-> ext_q && rate_q == scrse_pkg::RC_EXT)
      else $error("external trigger echoed without being selected");
   AST_UNKNOWN: assert property (@(posedge clock) disable iff (!reset_n)
      unknown_w |=> ##1 resp_valid_q && resp_code_q == scrse_pkg::RSP_E001 ##1 resp_code_q == scrse_pkg::RSP_PROMPT)
      else $error("unknown command not answered with E001 and prompt");
   AST_SAVE_NEEDS_Y: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(flash_wr_req_q) |-> $past(conf_yes_w) && $past(conf_q) == CK_SAVE)
      else $error("flash write started without upper-case Y");
   AST_SAVE_BAD_ANS: assert property (@(posedge clock) disable iff (!reset_n)
      conf_take_w && !conf_yes_w && !conf_no_w && conf_q == CK_SAVE |=>
      ##1 resp_code_q == scrse_pkg::RSP_SAVE_ABORTED ##1 resp_code_q == scrse_pkg::RSP_E003)
      else $error("bad save answer not aborted with E003");
   AST_SAVE_COUNT: assert property (@(posedge clock) disable iff (!reset_n)
      flash_end_w && flash_ok |=> save_cnt_q == $past(save_cnt_q) + 1'b1 && flash_rate_q == $past(rate_q))
      else $error("save counter or flash copy not updated");
   AST_WARN: assert property (@(posedge clock) disable iff (!reset_n)
      resp_valid_q && resp_code_q == scrse_pkg::RSP_E004 |-> save_cnt_q > CNT_W'(scrse_pkg::SAVE_WARN_LIMIT))
      else $error("E004 issued below the save limit");
   AST_FAIL: assert property (@(posedge clock) disable iff (!reset_n)
      flash_end_w && !flash_ok |=> ##1 resp_valid_q && resp_code_q == scrse_pkg::RSP_E005)
      else $error("flash failure not reported as E005");
   AST_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
      st_q == ST_HOLD && hold_cnt_q != 32'h00000000 |=> mode_q == scrse_pkg::MODE_SERVICE)
      else $error("service mode left during hold time");
   AST_NOW: assert property (@(posedge clock) disable iff (!reset_n)
      st_q == ST_SEND && q_len_q == 2'h1 && after_q == ST_LEAVE |=> ##1 mode_q == tgt_q)
      else $error("immediate exit did not change mode");
   AST_INIT_RELOAD: assert property (@(posedge clock) disable iff (!reset_n)
      mode_q == scrse_pkg::MODE_INIT |-> rate_q == flash_rate_q && !aux_diff_q)
      else $error("init mode entered without reloading flash settings");
   AST_CONF_BAD: assert property (@(posedge clock) disable iff (!reset_n)
      conf_take_w && !conf_yes_w && !conf_no_w && conf_q != CK_SAVE |=>
      ##1 resp_code_q == scrse_pkg::RSP_E003 && mode_q == scrse_pkg::MODE_SERVICE)
      else $error("bad exit answer not reported as E003");
   COV_RATE: cover property (@(posedge clock) disable iff (!reset_n) rate_apply_w && num_q != 11'h000);
   COV_SAVE: cover property (@(posedge clock) disable iff (!reset_n) flash_end_w && flash_ok);
   COV_EXIT_HOLD: cover property (@(posedge clock) disable iff (!reset_n) st_q == ST_LEAVE && tgt_q == scrse_pkg::MODE_NORMAL);
   COV_INIT: cover property (@(posedge clock) disable iff (!reset_n) mode_q == scrse_pkg::MODE_INIT);
endmodule : scrse_top

// ===== shared/scrse_pkg.sv
package scrse_pkg;
   // Characters seen on the service line
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_COMMA = 8'h2c;
   localparam logic [7:0] CH_D0 = 8'h30;
   localparam logic [7:0] CH_D9 = 8'h39;
   localparam logic [7:0] CH_RATE = 8'h6d;
   localparam logic [7:0] CH_SAVE = 8'h73;
   localparam logic [7:0] CH_EXIT = 8'h78;
   localparam logic [7:0] CH_NORM_CONF = 8'h6e;
   localparam logic [7:0] CH_INIT_CONF = 8'h69;
   localparam logic [7:0] CH_NORM_NOW = 8'h4e;
   localparam logic [7:0] CH_INIT_NOW = 8'h49;
   localparam logic [7:0] CH_YES = 8'h59;
   localparam logic [7:0] CH_NO = 8'h4e;

   // Sample rate parameter values and their codes
   localparam logic [10:0] RATE_V125 = 11'h07d;
   localparam logic [10:0] RATE_V250 = 11'h0fa;
   localparam logic [10:0] RATE_V500 = 11'h1f4;
   localparam logic [10:0] RATE_V1000 = 11'h3e8;
   localparam logic [10:0] NUM_LIMIT = 11'h065;
   localparam logic [2:0] RC_EXT = 3'h0;
   localparam logic [2:0] RC_125 = 3'h1;
   localparam logic [2:0] RC_250 = 3'h2;
   localparam logic [2:0] RC_500 = 3'h3;
   localparam logic [2:0] RC_1000 = 3'h4;
   localparam logic [2:0] RATE_RST = 3'h4;

   // Save counter
   localparam int SAVE_CNT_W = 16;
   localparam logic [15:0] SAVE_WARN_LIMIT = 16'h03e8;

   // Hold time before a confirmed exit executes
   localparam longint CLK_HZ = 100000000;
   localparam longint HOLD_TIME_S = 3;
   localparam int unsigned HOLD_CYC = 32'(HOLD_TIME_S * CLK_HZ);

   // Register offsets (byte addresses) and fields
   localparam logic [4:0] OFS_STATUS = 5'h00;
   localparam logic [4:0] OFS_SAVE_CNT = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_FLASH_RATE = 5'h0c;
   localparam int CTRL_SERVICE_BIT = 0;
   localparam int CTRL_AUX_DIFF_BIT = 1;

   typedef enum logic [1:0] {
      MODE_SERVICE,
      MODE_NORMAL,
      MODE_INIT
   } scrse_mode_t;

   typedef enum logic [3:0] {
      RSP_PROMPT,
      RSP_RATE,
      RSP_EXT_TRIG,
      RSP_ASK_SAVE,
      RSP_SAVED,
      RSP_SAVE_ABORTED,
      RSP_ASK_EXIT,
      RSP_RET_NORMAL,
      RSP_RET_INIT,
      RSP_E001,
      RSP_E002,
      RSP_E003,
      RSP_E004,
      RSP_E005
   } scrse_rsp_t;
endpackage : scrse_pkg

// ===== test/scrse_flash_model.sv
module scrse_flash_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic flash_wr_req,
   input wire logic fail,
   output logic flash_done,
   output logic flash_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] busy_q;
   // A save takes several cycles, so the wait state is really exercised
   always_ff @(posedge clock) begin
      if (!reset_n) busy_q <= 3'h0;
      else if (flash_wr_req) busy_q <= 3'h5;
      else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
   end
   assign flash_done = (busy_q == 3'h1);
   // Status toggles outside the done cycle, so no stale value helps
   assign flash_ok = flash_done ? !fail : busy_q[0];
endmodule : scrse_flash_model

// ===== test/scrse_top_tb.sv
module scrse_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, reset_n = 0, rx_valid = 0, read = 0, write = 0, fail = 0, waitrequest, resp_valid;
   logic ext_trig, flash_wr_req, flash_done, flash_ok;
   logic [7:0] rx_data = 8'h00;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata;
   logic [2:0] rate_code, flash_wr_rate;
   logic [15:0] save_count;
   scrse_pkg::scrse_rsp_t resp_code;
   scrse_pkg::scrse_mode_t mode;
   scrse_pkg::scrse_rsp_t got[$];
   int n_errors = 0, n_compared = 0, cyc = 0, k;
   always #5 clock = ~clock;
   scrse_top #(.HOLD_CYCLES(20)) u_dut (.clock(clock), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
      .flash_done(flash_done), .flash_ok(flash_ok), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .resp_valid(resp_valid),
      .resp_code(resp_code), .rate_code(rate_code), .ext_trig(ext_trig), .mode(mode),
      .flash_wr_req(flash_wr_req), .flash_wr_rate(flash_wr_rate), .save_count(save_count));
   scrse_flash_model u_flash (.clock(clock), .reset_n(reset_n), .flash_wr_req(flash_wr_req), .fail(fail),
      .flash_done(flash_done), .flash_ok(flash_ok));
   // Messages in arrival order; guard against a hang
   always @(posedge clock) begin
      if (resp_valid === 1'b1) got.push_back(resp_code);
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         end_sim();
      end
   end
   task end_sim;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Sends s, then expects messages e, one letter each: a is the first code
   task run(input string s, input string e);
      int i, w;
      for (i = 0; i < s.len(); i++) begin
         @(posedge clock);
         rx_valid <= 1'b1;
         rx_data <= s[i];
         @(posedge clock);
         rx_valid <= 1'b0;
         repeat (3) @(posedge clock);
      end
      for (w = 0; w < 300 && got.size() < e.len(); w++) @(posedge clock);
      repeat (3) @(posedge clock);
      check(got.size(), e.len());
      if (got.size() == e.len()) for (i = 0; i < e.len(); i++) check(got[i], scrse_pkg::scrse_rsp_t'(4'(e[i] - 8'h61)));
      got.delete();
      $display("test done: %s", e);
   endtask : run
   // One access; held until waitrequest is seen low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clock);
      write <= w;
      read <= !w;
      address <= a;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      if (!w) check(readdata, e);
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      run("m 0\015", "ca");
      check(ext_trig, 1);
      run("m 1000\015", "ba");
      check(rate_code, 4);
      run("m 7\015", "la");
      run("m ,5\015", "ka");
      run("q\015", "ja");
      run("m 500\015", "ba");
      check(rate_code, 3);
      run("s x\015", "ka");
      run("s\015N", "dfa");
      run("s\015y", "dfla");
      fail <= 1'b1;
      run("s\015Y", "dna");
      fail <= 1'b0;
      run("s\015Y", "dea");
      check(save_count, 1);
      check(flash_wr_rate, 3);
      bus(0, scrse_pkg::OFS_FLASH_RATE, 0, 32'h3);
      bus(0, scrse_pkg::OFS_STATUS, 0, 32'h3);
      bus(0, 5'h10, 0, 32'h0);
      for (k = 2; k <= 1000; k++) run("s\015Y", "dea");
      run("s\015Y", "dema");
      check(save_count, 1001);
      run("x n\015", "h");
      check(mode, scrse_pkg::MODE_SERVICE);
      repeat (25) @(posedge clock);
      check(mode, scrse_pkg::MODE_NORMAL);
      bus(1, scrse_pkg::OFS_CTRL, 1, 0);
      run("m 125\015", "ba");
      check(rate_code, 1);
      run("x n\015q", "gla");
      check(mode, scrse_pkg::MODE_SERVICE);
      run("x n\015N", "ga");
      check(mode, scrse_pkg::MODE_SERVICE);
      run("x i\015Y", "gi");
      repeat (30) @(posedge clock);
      check(mode, scrse_pkg::MODE_NORMAL);
      check(rate_code, 3);
      bus(1, scrse_pkg::OFS_CTRL, 1, 0);
      run("x N\015", "h");
      check(mode, scrse_pkg::MODE_NORMAL);
      bus(1, scrse_pkg::OFS_CTRL, 1, 0);
      run("x I\015", "i");
      check(mode, scrse_pkg::MODE_NORMAL);
      end_sim();
   end
endmodule : scrse_top_tb
